// File: epo_gen.sv
// Energy pulse output generator: counter, stepper and calibration pulses
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RQ1] Calibration rate is 128/64/32/16 times counter rate; half when scale low.
// [RQ2] Max calibration rate is 43.52 Hz scale high, 21.76 Hz low, any base.
// [RQ3] Calibration and counter pulses come from the same filtered power.
// [RQ4] Counter outputs pulse low alternately, first a then b.
// [RQ5] Counter pulses are 275 ms low when the period allows.
// [RQ6] Falling edge of b follows a by about half of a's period.
// [RQ7] Counter period under 550 ms gives pulse width of half the period.
// [RQ8] Calibration pulses are 90 ms high, rate proportional to power.
// [RQ9] Calibration period under 180 ms gives width of half the period.
// [RQ10] Loads below minimum frequency produce no pulse on any output.
// [RQ11] Minimum frequency is 0.0014 percent of full scale for the selected base.
// [RQ12] Base select codes pick base frequency 1.7, 3.4, 6.8 or 13.6 Hz.
// [RQ13] Half-scale AC gives 0.085, 0.17, 0.34, 0.68 Hz counter rates.
// [RQ14] Base frequency is master clock over 2^21 down to 2^18.
// [RQ15] Pulse rate scales with power product, gain and base frequency.
// [RQ16] Power accumulates per sample; a threshold crossing pulses and subtracts.
// [RQ17] Reset clears accumulators and timers, counters high, calibration low; the code presets cnt_gap and cal_gap to their maximum instead.
module epo_gen
   import epo_pkg::*;
#(
   parameter int                 PW          = 24,
   parameter logic [PW-1:0]      FULL_SCALE  = {PW{1'b1}},
   parameter logic [PW:0]        CAL_THRESH  = {1'b1, {PW{1'b0}}},
   parameter int                 CNT_W_CYC   = CNT_WIDTH_CYC,
   parameter int                 CAL_W_CYC   = CAL_WIDTH_CYC
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   // Filtered power product
   input  wire logic [PW-1:0] power_sample,
   input  wire logic          power_valid,
   // Rate selection pins
   input  wire logic          base_sel_lo,
   input  wire logic          base_sel_hi,
   input  wire logic          cal_scale_select,
   // Pulse outputs
   output logic               counter_pulse_a,
   output logic               counter_pulse_b,
   output logic               cal_pulse_out
);
   // ****************************************
   // Parameter checks
   // ****************************************
   localparam logic [TIMER_W-1:0] CNT_W = TIMER_W'(CNT_W_CYC);
   localparam logic [TIMER_W-1:0] CAL_W = TIMER_W'(CAL_W_CYC);
   localparam logic [TIMER_W-1:0] CAL_GAP_MAX = TIMER_W'(2 * CAL_W_CYC);
   localparam logic [PW-1:0] NOLOAD =
      PW'((64'(FULL_SCALE) * NOLOAD_PER_MILLION) / MILLION);

   generate
      // Threshold above 2^PW would let the doubled threshold outgrow the accumulator
      if (CNT_W_CYC < 1 || CAL_W_CYC < 1 || 2 * CAL_W_CYC >= 2 ** TIMER_W
          || CNT_W_CYC >= 2 ** TIMER_W || {1'b0, FULL_SCALE} > CAL_THRESH
          || CAL_THRESH > {1'b1, {PW{1'b0}}}) begin : g_bad
         $error("epo_gen: parameter values out of range");
      end
   endgenerate

   // ****************************************
   // Energy accumulation
   // ****************************************
   epo_sel_t         sel;
   logic [PW:0]      acc;
   logic [PW:0]      next_acc;
   logic [DIV_W-1:0] div;
   logic [DIV_W-1:0] next_div;
   logic [PW+1:0]    cal_thr;
   logic [2:0]       mult_log2;
   logic [DIV_W-1:0] div_last;
   logic [PW+1:0]    sum;
   logic             cal_ev;
   logic             cnt_ev;

   assign sel = '{scale: cal_scale_select, base: {base_sel_hi, base_sel_lo}};

   always_comb begin
      // Base code picks clock/2^(21-code): each step halves the ratio
      mult_log2 = MULT_LOG2_MAX - {1'b0, sel.base} - {2'b00, ~sel.scale}; // RQ1 RQ12 RQ13 RQ14
      div_last  = DIV_W'((8'h01 << mult_log2) - 8'h01);
      // Doubling the cal threshold when scale is low halves only that rate
      // Extra bit keeps the doubled threshold from wrapping to zero
      cal_thr   = sel.scale ? {1'b0, CAL_THRESH} : {CAL_THRESH, 1'b0}; // RQ2
      sum       = {1'b0, acc} + {2'b00, power_sample};
      next_acc  = acc;
      next_div  = div;
      cal_ev    = 1'b0;
      cnt_ev    = 1'b0;
      if (power_valid && power_sample >= NOLOAD) begin // RQ10 RQ11
         // Threshold exceeds full scale, so one crossing per sample at most
         if (sum >= cal_thr) begin // RQ16
            next_acc = (PW+1)'(sum - cal_thr);
            cal_ev   = 1'b1;
            // Counter events are a fixed fraction of cal events, same source
            if (div >= div_last) begin // RQ3 RQ15
               next_div = '0;
               cnt_ev   = 1'b1;
            end else begin
               next_div = div + DIV_W'(1);
            end
         end else begin
            next_acc = sum[PW:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= '0; // RQ17
         div <= '0;
      end else begin
         acc <= next_acc;
         div <= next_div;
      end
   end

   // ****************************************
   // Counter pulse pair
   // ****************************************
   logic [TIMER_W-1:0] cnt_gap;
   logic [TIMER_W-1:0] next_cnt_gap;
   logic [TIMER_W-1:0] cnt_left;
   logic [TIMER_W-1:0] next_cnt_left;
   logic               cnt_phase_b;
   logic               next_cnt_phase_b;
   logic               next_pa;
   logic               next_pb;

   always_comb begin
      next_cnt_gap     = (cnt_gap < CNT_W) ? cnt_gap + TIMER_W'(1) : cnt_gap;
      next_cnt_left    = (cnt_left != '0) ? cnt_left - TIMER_W'(1) : cnt_left;
      next_cnt_phase_b = cnt_phase_b;
      next_pa          = counter_pulse_a;
      next_pb          = counter_pulse_b;
      if (next_cnt_left == '0) begin
         next_pa = PULSE_IDLE_CNT;
         next_pb = PULSE_IDLE_CNT;
      end
      if (cnt_ev) begin
         // Gap saturates at the fixed width: min(275 ms, half of a's period)
         next_cnt_left    = cnt_gap; // RQ5 RQ7
         next_cnt_gap     = TIMER_W'(1);
         next_cnt_phase_b = ~cnt_phase_b; // RQ4 RQ6
         next_pa          = cnt_phase_b;
         next_pb          = ~cnt_phase_b;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_gap         <= CNT_W; // RQ17
         cnt_left        <= '0;
         cnt_phase_b     <= 1'b0;
         counter_pulse_a <= PULSE_IDLE_CNT;
         counter_pulse_b <= PULSE_IDLE_CNT;
      end else begin
         cnt_gap         <= next_cnt_gap;
         cnt_left        <= next_cnt_left;
         cnt_phase_b     <= next_cnt_phase_b;
         counter_pulse_a <= next_pa;
         counter_pulse_b <= next_pb;
      end
   end

   // ****************************************
   // Calibration pulse
   // ****************************************
   logic [TIMER_W-1:0] cal_gap;
   logic [TIMER_W-1:0] next_cal_gap;
   logic [TIMER_W-1:0] cal_left;
   logic [TIMER_W-1:0] next_cal_left;
   logic               next_cal;

   always_comb begin
      next_cal_gap  = (cal_gap < CAL_GAP_MAX) ? cal_gap + TIMER_W'(1) : cal_gap;
      next_cal_left = (cal_left != '0) ? cal_left - TIMER_W'(1) : cal_left;
      next_cal      = (next_cal_left != '0);
      if (cal_ev) begin
         // Width follows the last period, so a rate step lags one pulse
         next_cal_left = {1'b0, cal_gap[TIMER_W-1:1]}; // RQ8 RQ9
         next_cal_gap  = TIMER_W'(1);
         next_cal      = (next_cal_left != '0);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_gap       <= CAL_GAP_MAX; // RQ17
         cal_left      <= '0;
         cal_pulse_out <= PULSE_IDLE_CAL;
      end else begin
         cal_gap       <= next_cal_gap;
         cal_left      <= next_cal_left;
         cal_pulse_out <= next_cal;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   logic [TIMER_W-1:0] cal_hi_run;
   logic [TIMER_W-1:0] a_lo_run;
   logic [TIMER_W-1:0] b_lo_run;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_hi_run <= '0;
         a_lo_run   <= '0;
         b_lo_run   <= '0;
      end else begin
         cal_hi_run <= cal_pulse_out ? cal_hi_run + TIMER_W'(1) : '0;
         // Separate runs: a pulse may end on the edge where the other starts
         a_lo_run   <= !counter_pulse_a ? a_lo_run + TIMER_W'(1) : '0;
         b_lo_run   <= !counter_pulse_b ? b_lo_run + TIMER_W'(1) : '0;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_quiet_sample;
      power_valid && power_sample < NOLOAD;
   endsequence

   sequence s_cnt_start_a;
      cnt_ev && !cnt_phase_b;
   endsequence

   sequence s_a_falls;
      ##1 !counter_pulse_a && counter_pulse_b;
   endsequence

   AST_NOLOAD_HOLD: assert property (s_quiet_sample |=> $stable(acc)) // RQ10
      else $error("accumulator moved on a sub-threshold sample");
   AST_CNT_NEEDS_CAL: assert property (cnt_ev |-> cal_ev) // RQ1
      else $error("counter event without a cal event");
   AST_A_FIRST: assert property (s_cnt_start_a |-> s_a_falls) // RQ4
      else $error("counter output a did not pulse alone");
   AST_ALTERNATE: assert property (cnt_ev && cnt_phase_b |=> !counter_pulse_b && counter_pulse_a) // RQ6
      else $error("counter output b did not take its turn");
   AST_NO_OVERLAP: assert property (!(!counter_pulse_a && !counter_pulse_b)) // RQ4
      else $error("both counter outputs low together");
   AST_CNT_WIDTH: assert property (a_lo_run <= CNT_W && b_lo_run <= CNT_W) // RQ5 RQ7
      else $error("counter pulse longer than fixed width");
   AST_CAL_WIDTH: assert property (cal_hi_run <= CAL_W) // RQ8
      else $error("cal pulse longer than fixed width");
   AST_CAL_HALF: assert property (cal_ev && cal_gap > TIMER_W'(1) |=>
                                  cal_pulse_out && cal_left <= ($past(cal_gap) >> 1)) // RQ9
      else $error("cal pulse width not bounded by half the period");
   AST_CAL_SUB: assert property (cal_ev |=> acc < {1'b0, $past(power_sample)}) // RQ16
      else $error("threshold not subtracted on cal event");
endmodule
`default_nettype wire

// File: epo_pkg.sv
// Constants and types shared by the energy pulse output generator
package epo_pkg;
   // ****************************************
   // Clock and pulse timing
   // ****************************************
   localparam int CLK_HZ       = 25_000_000;
   localparam int MS_PER_S     = 1000;
   localparam int CNT_WIDTH_MS = 275;
   localparam int CNT_SPLIT_MS = 550;
   localparam int CAL_WIDTH_MS = 90;
   localparam int CAL_SPLIT_MS = 180;
   localparam int CNT_WIDTH_CYC = (CLK_HZ / MS_PER_S) * CNT_WIDTH_MS;
   localparam int CAL_WIDTH_CYC = (CLK_HZ / MS_PER_S) * CAL_WIDTH_MS;
   localparam int TIMER_W      = 24;

   // ****************************************
   // Rate scaling
   // ****************************************
   localparam int          NOLOAD_PER_MILLION = 14;
   localparam int          MILLION            = 1_000_000;
   localparam int          DIV_W              = 7;
   localparam logic [2:0]  MULT_LOG2_MAX      = 3'h7;
   localparam logic        PULSE_IDLE_CNT     = 1'b1;
   localparam logic        PULSE_IDLE_CAL     = 1'b0;

   typedef struct packed {
      logic       scale;
      logic [1:0] base;
   } epo_sel_t;
endpackage

// File: epo_pulse_sink.sv
// Far-side pulse counter model that counts and times the generator outputs
`timescale 1ns/100ps
`default_nettype none
module epo_pulse_sink (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Pulse lines from the generator
   input  wire logic        cnt_a,
   input  wire logic        cnt_b,
   input  wire logic        cal,
   // Observations
   output logic [15:0]      n_cal,
   output logic [15:0]      n_cnt,
   output logic [15:0]      w_cal,
   output logic [15:0]      w_a,
   output logic [15:0]      lag,
   output logic             order_bad
);
   logic        pa;
   logic        pb;
   logic        pc;
   logic        want_b;
   logic [15:0] c_cal;
   logic [15:0] c_a;
   logic [15:0] c_lag;
   // Edges seen on clock samples, like a counting input would see them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {pa, pb, pc, want_b, order_bad} <= 5'h18;
         {n_cal, n_cnt, w_cal, w_a, lag} <= '0;
         {c_cal, c_a, c_lag} <= '0;
      end else begin
         pa <= cnt_a;
         pb <= cnt_b;
         pc <= cal;
         if (cal && !pc) n_cal <= n_cal + 16'h1;
         c_cal <= cal ? (pc ? c_cal + 16'h1 : 16'h1) : c_cal;
         if (!cal && pc) w_cal <= c_cal;
         c_a <= !cnt_a ? (pa ? 16'h1 : c_a + 16'h1) : c_a;
         if (cnt_a && !pa) w_a <= c_a;
         c_lag <= (!cnt_a && pa) ? 16'h1 : c_lag + 16'h1;
         if (!cnt_b && pb) lag <= c_lag;
         if ((!cnt_a && pa) || (!cnt_b && pb)) begin
            n_cnt <= n_cnt + 16'h1;
            want_b <= !(!cnt_b && pb);
            // Two-phase stepper loses a step if a phase repeats
            if (want_b ? (!cnt_a && pa) : (!cnt_b && pb)) order_bad <= 1'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking testbench for the energy pulse output generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import epo_pkg::*;
   // ****************************************
   // Set-up
   // ****************************************
   localparam int          CNT_W  = 40;
   localparam int          CAL_W  = 12;
   localparam logic [23:0] HALF   = 24'h800000;
   localparam logic [23:0] NOLOAD = 24'((64'hFFFFFF * NOLOAD_PER_MILLION) / MILLION);
   logic        ref_clk;
   logic        rst_n;
   logic        power_valid;
   logic [23:0] power_sample;
   logic [2:0]  sel;
   wire logic   counter_pulse_a;
   wire logic   counter_pulse_b;
   wire logic   cal_pulse_out;
   wire logic [15:0] n_cal, n_cnt, w_cal, w_a, lag;
   wire logic   order_bad;
   int          n_mismatch = 0;
   int          n_compared = 0;

   epo_gen #(.CNT_W_CYC(CNT_W), .CAL_W_CYC(CAL_W)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
      .power_sample(power_sample), .power_valid(power_valid), .base_sel_lo(sel[0]),
      .base_sel_hi(sel[1]), .cal_scale_select(sel[2]), .counter_pulse_a(counter_pulse_a),
      .counter_pulse_b(counter_pulse_b), .cal_pulse_out(cal_pulse_out));
   epo_pulse_sink SINK (.clk(ref_clk), .rst_n(rst_n), .cnt_a(counter_pulse_a),
      .cnt_b(counter_pulse_b), .cal(cal_pulse_out), .n_cal(n_cal), .n_cnt(n_cnt),
      .w_cal(w_cal), .w_a(w_a), .lag(lag), .order_bad(order_bad));

   initial begin
      ref_clk = 1'h0;
      forever #20 ref_clk = ~ref_clk;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic do_reset(input int n);
      rst_n = 1'h0;
      tick(n);
      chk("idle_outputs", 32'({counter_pulse_a, counter_pulse_b, cal_pulse_out}), 32'h6);
      rst_n = 1'h1;
      tick(1);
   endtask
   // Accumulator preloaded just under threshold, then a sub-threshold load
   task automatic scen_noload();
      sel = 3'h4;
      do_reset(2);
      power_sample = 24'hFFFFFF;
      power_valid = 1'h1;
      tick(1);
      power_sample = NOLOAD - 24'h1;
      tick(1);
      power_valid = 1'h0;
      tick(4);
      chk("cal_events_below", 32'(n_cal), 32'h0);
      power_sample = NOLOAD;
      power_valid = 1'h1;
      tick(1);
      power_valid = 1'h0;
      tick(CAL_W + 4);
      chk("cal_events_at", 32'(n_cal), 32'h1);
      chk("cal_width_first", 32'(w_cal), 32'(CAL_W));
   endtask
   // Half-scale samples every gap cycles until n_ev counter events
   task automatic run_case(input logic [2:0] s, input int gap, input int n_ev);
      int mult, spc, ival, ew;
      mult = (s[2] ? 128 : 64) >> s[1:0];
      spc = s[2] ? 2 : 4;
      ival = gap * spc * mult;
      sel = s;
      do_reset(2);
      power_sample = HALF;
      for (int i = 0; i < n_ev * mult * spc; i++) begin
         power_valid = 1'h1;
         tick(1);
         if (gap > 1) begin
            power_valid = 1'h0;
            tick(gap - 1);
         end
      end
      power_valid = 1'h0;
      tick(CNT_W + 8);
      ew = ival < CNT_W ? ival : CNT_W;
      chk("counter_events", 32'(n_cnt), 32'(n_ev));
      chk("order_fault", 32'(order_bad), 32'h0);
      chk("counter_width", 32'(w_a), 32'(ew));
      chk("fall_lag", 32'(lag), 32'(ival));
      // Short cal gaps merge with the wide first pulse, so count only slow runs
      if (gap >= 8) begin
         ew = gap * spc / 2 < CAL_W ? gap * spc / 2 : CAL_W;
         chk("cal_events", 32'(n_cal), 32'(n_ev * mult));
         chk("cal_width", 32'(w_cal), 32'(ew));
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n = 1'h0;
      power_valid = 1'h0;
      power_sample = 24'h0;
      sel = 3'h0;
      tick(20);
      rst_n = 1'h1;
      tick(1);
      scen_noload();
      for (int k = 0; k < 8; k++) begin
         run_case(3'(k), 8, 2);
      end
      run_case(3'h7, 1, 4);
      close_out();
   end
endmodule
`default_nettype wire
